// ### rtl/uc_defines.svh
// Register offsets, bit positions and build defaults of the serial transceiver.
// Assumes inclusion by bare name from rtl files.
`ifndef UC_DEFINES_SVH
`define UC_DEFINES_SVH

// ----------------------------------------
// Word offsets on the slave port
// ----------------------------------------
`define UC_OFF_RXDATA  3'h0
`define UC_OFF_TXDATA  3'h1
`define UC_OFF_STATUS  3'h2
`define UC_OFF_CONTROL 3'h3
`define UC_OFF_DIVISOR 3'h4
`define UC_OFF_EOPCHAR 3'h5

// ----------------------------------------
// Status and control bit positions
// ----------------------------------------
`define UC_ST_PAR_FAULT  0
`define UC_ST_FE         1
`define UC_ST_ROE        3
`define UC_ST_TOE        4
`define UC_ST_TMT        5
`define UC_ST_TRDY       6
`define UC_ST_RRDY       7
`define UC_ST_CLR_CHG    10
`define UC_ST_CTS        11
`define UC_ST_PKT_END    12
`define UC_CT_CLR_CHG_IE 10
`define UC_CT_RTS        11
`define UC_CT_PKT_END_IE 12

// ----------------------------------------
// Build defaults and reset values
// ----------------------------------------
`define UC_DATA_BITS   8
`define UC_STOP_BITS   1
`define UC_SYNC_STAGES 2
`define UC_FIXED_DIV   16'h06c8
`define UC_PKT_END_RESET 9'h000

`endif

// ### rtl/uc_pkg.sv
// Types shared by the serial transceiver files.
// Assumes nothing beyond a SystemVerilog compiler.
package uc_pkg;

	typedef enum logic [1:0] {
		UC_PAR_NONE,
		UC_PAR_EVEN,
		UC_PAR_ODD
	} uc_parity_t;

	// Slave port request, held by the master while stalled
	typedef struct packed {
		logic        cs;
		logic        rd;
		logic        wr;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} uc_bus_req_t;

endpackage : uc_pkg

// ### rtl/uc_sync.sv
// Parameterised flip-flop chain for asynchronous pin inputs.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module uc_sync #(
	parameter int   STAGES  = 2,
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Pin in, synchronised out
	input  wire logic d_i,
	output logic      q_o
);

	logic [STAGES-1:0] chain_r;

	// Only the last stage is read; more stages cost one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chain_r <= {STAGES{RST_VAL}};
		end else begin
			chain_r <= {chain_r[STAGES-2:0], d_i};
		end
	end

	assign q_o = chain_r[STAGES-1];

endmodule : uc_sync

`default_nettype wire

// ### rtl/uc_tx.sv
// Serial transmitter: start bit, data, optional parity, stop bits.
// Assumes load_i only while busy_o is low.
`timescale 1ns/100ps
`default_nettype none

module uc_tx #(
	parameter int              DW        = 8,
	parameter int              STOP_BITS = 1,
	parameter uc_pkg::uc_parity_t PARITY = uc_pkg::UC_PAR_NONE
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Character in
	input  wire logic          load_i,
	input  wire logic [DW-1:0] data_i,
	input  wire logic [15:0]   div_i,
	// Line
	output logic               txd_o,
	output logic               busy_o
);

	localparam int HAS_PAR = (PARITY != uc_pkg::UC_PAR_NONE) ? 1 : 0;
	localparam int NREST   = DW + HAS_PAR + STOP_BITS;

	logic [11:0] frame;
	logic [11:0] sh_r;
	logic [3:0]  left_r;
	logic [15:0] cnt_r;
	logic        pbit;

	always_comb begin
		pbit = (PARITY == uc_pkg::UC_PAR_EVEN) ? ^data_i : ~^data_i;
		frame = 12'hfff; // Upper ones serve as stop bits
		frame[DW-1:0] = data_i;
		if (HAS_PAR != 0) begin
			frame[DW] = pbit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txd_o  <= 1'b1;
			busy_o <= 1'b0;
			sh_r   <= 12'hfff;
			left_r <= 4'h0;
			cnt_r  <= 16'h0000;
		end else if (load_i) begin
			txd_o  <= 1'b0;
			busy_o <= 1'b1;
			sh_r   <= frame;
			left_r <= 4'(NREST);
			cnt_r  <= div_i;
		end else if (busy_o && cnt_r == 16'h0000) begin
			cnt_r <= div_i;
			if (left_r == 4'h0) begin
				busy_o <= 1'b0;
				txd_o  <= 1'b1;
			end else begin
				txd_o  <= sh_r[0];
				sh_r   <= {1'b1, sh_r[11:1]};
				left_r <= left_r - 4'h1;
			end
		end else if (busy_o) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

endmodule : uc_tx

`default_nettype wire

// ### rtl/uc_uart.sv
// Serial transceiver core with slave register port and build options.
// Assumes a master that holds its request while waitrequest_o is high.
`timescale 1ns/100ps
`default_nettype none
`include "uc_defines.svh"

// Functional notes
// - Optional writable 16-bit divisor at offset 4
// - Without it, fixed divisor; offset 4 inert
// - Data width 7, 8 or 9 bits
// - One or two stop bits transmitted
// - Receiver stops at first stop bit
// - No parity: none sent, flag reads 0
// - Odd/even parity generated and checked
// - Bad parity sets the parity fault flag
// - Even: bit 0 on even ones count
// - Odd: bit 0 on odd ones count
// - Pin inputs pass configurable synchroniser chains
// - Handshake option enables the always-present pins and its bits
// - Handshake pins never throttle the datapath
// - Without handshake, its bits read 0
// - Flow control stalls writes and reads
// - Packet-end character register at offset 5
// - Packet-end flag, enable and sideband signal
// - Matching character flags and ends transfer
// - Without packet-end, offset 5 inert
// - Width, stops, parity fixed at build
// - Transmit least significant bit first
// - Received character copied immediately when complete
module uc_uart #(
	parameter int                 DW          = `UC_DATA_BITS,
	parameter int                 STOP_BITS   = `UC_STOP_BITS,
	parameter uc_pkg::uc_parity_t PARITY      = uc_pkg::UC_PAR_NONE,
	parameter int                 SYNC_STAGES = `UC_SYNC_STAGES,
	parameter bit                 HAS_DIV     = 1'b1,
	parameter bit                 HAS_HS      = 1'b1,
	parameter bit                 HAS_FLOW    = 1'b1,
	parameter bit                 HAS_PKT_END = 1'b1,
	parameter logic [15:0]        FIXED_DIV   = `UC_FIXED_DIV
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Slave port
	input  wire uc_pkg::uc_bus_req_t bus_i,
	output logic [15:0]              readdata_o,
	output logic                     waitrequest_o,
	output logic                     dataavailable_o,
	output logic                     readyfordata_o,
	output logic                     endofpacket_o,
	output logic                     irq_o,
	// Serial line and handshake
	input  wire logic                rxd_i,
	input  wire logic                cts_n_i,
	output logic                     txd_o,
	output logic                     rts_n_o
);

	typedef enum logic [2:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_PAR,
		RX_STOP
	} uc_rx_state_t;

	localparam bit HAS_PAR = (PARITY != uc_pkg::UC_PAR_NONE);

	// ----------------------------------------
	// Slave port handshake
	// ----------------------------------------
	logic        access;
	logic        stall;
	logic        go;
	logic        wr_go;
	logic        rd_go;
	logic        trdy_r;
	logic        rrdy_r;

	// A request completes one cycle after it is taken; waitrequest stays high otherwise
	always_comb begin
		access = bus_i.cs & (bus_i.rd | bus_i.wr) & waitrequest_o;
		stall  = HAS_FLOW &&
			((bus_i.wr && bus_i.addr == `UC_OFF_TXDATA && !trdy_r) ||
			 (bus_i.rd && bus_i.addr == `UC_OFF_RXDATA && !rrdy_r));
		go     = access & ~stall;
		wr_go  = go & bus_i.wr;
		rd_go  = go & bus_i.rd;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			waitrequest_o <= 1'b1;
		end else begin
			waitrequest_o <= ~go;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [15:0]   div_r;
	logic [15:0]   div_w;
	logic [DW-1:0] eopch_r;
	logic          rts_r;
	logic          clr_chg_ie_r;
	logic          pkt_end_ie_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= FIXED_DIV;
		end else if (HAS_DIV && wr_go && bus_i.addr == `UC_OFF_DIVISOR) begin
			div_r <= bus_i.wdata;
		end
	end

	// Fixed divisor when the register is left out
	assign div_w = HAS_DIV ? div_r : FIXED_DIV;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eopch_r <= DW'(`UC_PKT_END_RESET);
		end else if (HAS_PKT_END && wr_go && bus_i.addr == `UC_OFF_EOPCHAR) begin
			eopch_r <= bus_i.wdata[DW-1:0];
		end
	end

	// Only implemented control bits are stored; data format has no control bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rts_r        <= 1'b0;
			clr_chg_ie_r <= 1'b0;
			pkt_end_ie_r <= 1'b0;
		end else if (wr_go && bus_i.addr == `UC_OFF_CONTROL) begin
			rts_r        <= HAS_HS & bus_i.wdata[`UC_CT_RTS];
			clr_chg_ie_r <= HAS_HS & bus_i.wdata[`UC_CT_CLR_CHG_IE];
			pkt_end_ie_r <= HAS_PKT_END & bus_i.wdata[`UC_CT_PKT_END_IE];
		end
	end

	// ----------------------------------------
	// Pin synchronisers and handshake
	// ----------------------------------------
	logic rxd_s;
	logic cts_n_s;
	logic cts_r;
	logic clr_chg_r;
	logic clr_st;

	uc_sync #(
		.STAGES  (SYNC_STAGES),
		.RST_VAL (1'b1)
	) u_rx_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (rxd_i),
		.q_o   (rxd_s)
	);

	uc_sync #(
		.STAGES  (SYNC_STAGES),
		.RST_VAL (1'b1)
	) u_cts_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (cts_n_i),
		.q_o   (cts_n_s)
	);

	assign clr_st = wr_go && bus_i.addr == `UC_OFF_STATUS;

	// Handshake only feeds status and interrupt; transmitter never looks at it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cts_r     <= 1'b0;
			clr_chg_r <= 1'b0;
		end else begin
			cts_r <= HAS_HS & ~cts_n_s;
			if (HAS_HS && cts_r != ~cts_n_s) begin
				clr_chg_r <= 1'b1;
			end else if (clr_st) begin
				clr_chg_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rts_n_o <= 1'b1;
		end else begin
			rts_n_o <= ~rts_r;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	uc_rx_state_t  rx_state_r;
	logic [15:0]   rx_cnt_r;
	logic [3:0]    rx_idx_r;
	logic [DW-1:0] rx_sh_r;
	logic          rx_pbit_r;
	logic          rx_tick;
	logic          rx_done;
	logic          rx_pexp;

	assign rx_tick = (rx_cnt_r == 16'h0000);
	assign rx_done = (rx_state_r == RX_STOP) && rx_tick;
	assign rx_pexp = (PARITY == uc_pkg::UC_PAR_EVEN) ? ^rx_sh_r : ~^rx_sh_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state_r <= RX_IDLE;
			rx_cnt_r   <= 16'h0000;
			rx_idx_r   <= 4'h0;
			rx_sh_r    <= '0;
			rx_pbit_r  <= 1'b0;
		end else begin
			unique case (rx_state_r)
				RX_IDLE: begin
					if (!rxd_s) begin
						rx_state_r <= RX_START;
						rx_cnt_r   <= {1'b0, div_w[15:1]};
					end
				end
				RX_START: begin
					if (!rx_tick) begin
						rx_cnt_r <= rx_cnt_r - 16'h0001;
					end else if (rxd_s) begin
						rx_state_r <= RX_IDLE; // Glitch, not a start bit
					end else begin
						rx_state_r <= RX_DATA;
						rx_cnt_r   <= div_w;
						rx_idx_r   <= 4'h0;
					end
				end
				RX_DATA: begin
					if (!rx_tick) begin
						rx_cnt_r <= rx_cnt_r - 16'h0001;
					end else begin
						rx_sh_r  <= {rxd_s, rx_sh_r[DW-1:1]};
						rx_idx_r <= rx_idx_r + 4'h1;
						rx_cnt_r <= div_w;
						if (rx_idx_r == 4'(DW - 1)) begin
							rx_state_r <= HAS_PAR ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (!rx_tick) begin
						rx_cnt_r <= rx_cnt_r - 16'h0001;
					end else begin
						rx_pbit_r  <= rxd_s;
						rx_cnt_r   <= div_w;
						rx_state_r <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (!rx_tick) begin
						rx_cnt_r <= rx_cnt_r - 16'h0001;
					end else begin
						rx_state_r <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Receive holding register and flags
	// ----------------------------------------
	logic [DW-1:0] rxdata_r;
	logic          par_fault_r;
	logic          fe_r;
	logic          roe_r;
	logic          pkt_end_r;
	logic          rx_rd;
	logic          tx_wr;

	assign rx_rd = rd_go && bus_i.addr == `UC_OFF_RXDATA;
	assign tx_wr = wr_go && bus_i.addr == `UC_OFF_TXDATA;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxdata_r <= '0;
		end else if (rx_done) begin
			rxdata_r <= rx_sh_r;
		end
	end

	// Hardware set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rrdy_r <= 1'b0;
		end else if (rx_done) begin
			rrdy_r <= 1'b1;
		end else if (rx_rd) begin
			rrdy_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			par_fault_r <= 1'b0;
			fe_r        <= 1'b0;
			roe_r       <= 1'b0;
		end else begin
			if (HAS_PAR && rx_done && rx_pbit_r != rx_pexp) begin
				par_fault_r <= 1'b1;
			end else if (clr_st) begin
				par_fault_r <= 1'b0;
			end
			if (rx_done && !rxd_s) begin
				fe_r <= 1'b1;
			end else if (clr_st) begin
				fe_r <= 1'b0;
			end
			if (rx_done && rrdy_r && !rx_rd) begin
				roe_r <= 1'b1;
			end else if (clr_st) begin
				roe_r <= 1'b0;
			end
		end
	end

	// Packet end seen on either direction of the stream
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pkt_end_r <= 1'b0;
		end else if (HAS_PKT_END && ((rx_done && rx_sh_r == eopch_r) ||
				(tx_wr && bus_i.wdata[DW-1:0] == eopch_r))) begin
			pkt_end_r <= 1'b1;
		end else if (clr_st) begin
			pkt_end_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Transmit holding register
	// ----------------------------------------
	logic [DW-1:0] txhold_r;
	logic          tx_busy;
	logic          tx_load;
	logic          toe_r;

	assign tx_load = ~trdy_r & ~tx_busy;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txhold_r <= '0;
			trdy_r   <= 1'b1;
		end else begin
			if (tx_load) begin
				trdy_r <= 1'b1;
			end
			if (tx_wr) begin
				txhold_r <= bus_i.wdata[DW-1:0];
				trdy_r   <= 1'b0;
			end
		end
	end

	// Without flow control a write over a pending character loses it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			toe_r <= 1'b0;
		end else if (tx_wr && !trdy_r && !tx_load) begin
			toe_r <= 1'b1;
		end else if (clr_st) begin
			toe_r <= 1'b0;
		end
	end

	uc_tx #(
		.DW        (DW),
		.STOP_BITS (STOP_BITS),
		.PARITY    (PARITY)
	) u_tx (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.load_i (tx_load),
		.data_i (txhold_r),
		.div_i  (div_w),
		.txd_o  (txd_o),
		.busy_o (tx_busy)
	);

	// ----------------------------------------
	// Read data, sideband and interrupt
	// ----------------------------------------
	logic [15:0] status_w;

	always_comb begin
		status_w              = 16'h0000;
		status_w[`UC_ST_PAR_FAULT] = par_fault_r;
		status_w[`UC_ST_FE]        = fe_r;
		status_w[`UC_ST_ROE]       = roe_r;
		status_w[`UC_ST_TOE]       = toe_r;
		status_w[`UC_ST_TMT]       = trdy_r & ~tx_busy;
		status_w[`UC_ST_TRDY]      = trdy_r;
		status_w[`UC_ST_RRDY]      = rrdy_r;
		status_w[`UC_ST_CLR_CHG]   = clr_chg_r;
		status_w[`UC_ST_CTS]       = cts_r;
		status_w[`UC_ST_PKT_END]   = pkt_end_r;
	end

	// Unmapped offsets and absent options read as zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			readdata_o <= 16'h0000;
		end else if (rd_go) begin
			unique case (bus_i.addr)
				`UC_OFF_RXDATA:  readdata_o <= 16'(rxdata_r);
				`UC_OFF_STATUS:  readdata_o <= status_w;
				`UC_OFF_CONTROL: readdata_o <= {3'h0, pkt_end_ie_r, rts_r, clr_chg_ie_r, 10'h000};
				`UC_OFF_DIVISOR: readdata_o <= HAS_DIV ? div_r : 16'h0000;
				`UC_OFF_EOPCHAR: readdata_o <= HAS_PKT_END ? 16'(eopch_r) : 16'h0000;
				default:         readdata_o <= 16'h0000;
			endcase
		end
	end

	// Sideband ends a read or a write at the terminating character
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			endofpacket_o <= 1'b0;
		end else if (go) begin
			endofpacket_o <= HAS_PKT_END && ((rx_rd && rxdata_r == eopch_r) ||
				(tx_wr && bus_i.wdata[DW-1:0] == eopch_r));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dataavailable_o <= 1'b0;
			readyfordata_o  <= 1'b0;
			irq_o           <= 1'b0;
		end else begin
			dataavailable_o <= rrdy_r;
			readyfordata_o  <= trdy_r;
			irq_o           <= (clr_chg_r & clr_chg_ie_r) | (pkt_end_r & pkt_end_ie_r);
		end
	end

endmodule : uc_uart

`default_nettype wire

// ### verif/uc_uart_monitor.sv
// Checker for the transceiver slave port and pins.
// Assumes binding onto uc_uart, one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none

module uc_uart_monitor (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Slave port
	input  wire uc_pkg::uc_bus_req_t bus_i,
	input  wire logic [15:0]         readdata_o,
	input  wire logic                waitrequest_o,
	input  wire logic                dataavailable_o,
	input  wire logic                readyfordata_o,
	input  wire logic                endofpacket_o,
	input  wire logic                irq_o,
	// Pins
	input  wire logic                txd_o,
	input  wire logic                rts_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_rx_pend;
		bus_i.cs && bus_i.rd && bus_i.addr == 3'h0 && waitrequest_o;
	endsequence
	sequence s_tx_pend;
		bus_i.cs && bus_i.wr && bus_i.addr == 3'h1 && waitrequest_o;
	endsequence

	// Ready flags lag one cycle, so judge the stall one cycle on
	property p_rd_stall;
		s_rx_pend ##1 !dataavailable_o |-> waitrequest_o;
	endproperty
	property p_wr_stall;
		s_tx_pend ##1 !readyfordata_o |-> waitrequest_o;
	endproperty
	property p_wait_pulse;
		$fell(waitrequest_o) |=> waitrequest_o;
	endproperty
	property p_wait_cause;
		!waitrequest_o |-> $past(bus_i.cs && (bus_i.rd || bus_i.wr));
	endproperty
	property p_pkt_end_cycle;
		$rose(endofpacket_o) |-> !waitrequest_o;
	endproperty
	property p_pkt_end_src;
		$rose(endofpacket_o) |-> $past(bus_i.addr) inside {3'h0, 3'h1};
	endproperty
	property p_rts_cause;
		$changed(rts_n_o) |-> $past(bus_i.wr && bus_i.addr == 3'h3)
			|| $past(bus_i.wr && bus_i.addr == 3'h3, 2);
	endproperty
	property p_rdata_hold;
		$changed(readdata_o) |-> !waitrequest_o;
	endproperty
	property p_rst_out;
		$fell(rst_i) |-> waitrequest_o && txd_o && rts_n_o && !irq_o && !endofpacket_o;
	endproperty

	a_rd_stall: assert property (p_rd_stall) else $error("read taken with no char");
	a_wr_stall: assert property (p_wr_stall) else $error("write taken while full");
	a_wait_pulse: assert property (p_wait_pulse) else $error("ack longer than one");
	a_wait_cause: assert property (p_wait_cause) else $error("ack without request");
	a_pkt_end_cycle: assert property (p_pkt_end_cycle) else $error("packet end off completion");
	a_pkt_end_src: assert property (p_pkt_end_src) else $error("packet end on non-data access");
	a_rts_cause: assert property (p_rts_cause) else $error("rts moved by itself");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	a_rst_out: assert property (p_rst_out) else $error("bad outputs after reset");
endmodule : uc_uart_monitor

bind uc_uart uc_uart_monitor mon (
	.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .dataavailable_o(dataavailable_o),
	.readyfordata_o(readyfordata_o), .endofpacket_o(endofpacket_o),
	.irq_o(irq_o), .txd_o(txd_o), .rts_n_o(rts_n_o)
);
`default_nettype wire

// ### verif/uc_term_model.sv
// Terminal on the far side of the serial line.
// Assumes a bit time of BIT_CLKS whole clocks, even parity, 8 data bits.
`timescale 1ns/100ps
`default_nettype none

module uc_term_model #(
	parameter int BIT_CLKS = 4
) (
	// Clock
	input  wire logic clk_i,
	// Line
	input  wire logic txd_i,
	output var logic  rxd_o
);
	logic [11:0] frames [$];
	logic [11:0] fr;

	// Samples mid-bit: start, data, parity, two stops
	initial begin
		rxd_o = 1'b1;
		forever begin
			@(negedge txd_i);
			repeat (BIT_CLKS / 2) @(posedge clk_i);
			fr[0] = txd_i;
			for (int i = 1; i < 12; i++) begin
				repeat (BIT_CLKS) @(posedge clk_i);
				fr[i] = txd_i;
			end
			frames.push_back(fr);
		end
	end

	// One stop bit only: a receiver must not wait for more
	task automatic send(input logic [7:0] d, input logic bad);
		logic [10:0] bits;
		bits = {1'b1, ^d ^ bad, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk_i);
			rxd_o <= bits[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
	endtask : send
endmodule : uc_term_model
`default_nettype wire

// ### verif/uart_config_options_test.sv
// Self-checking bench for the transceiver, even parity, two stop bits.
// Assumes the terminal model on the line and the bound checker.
`timescale 1ns/100ps
`default_nettype none

module uart_config_options_test;
	typedef struct packed {
		logic [2:0]  a;
		logic [15:0] w;
		logic [15:0] r;
	} uc_row_t;

	logic                clk_i;
	logic                rst_i;
	uc_pkg::uc_bus_req_t bus_i;
	logic [15:0]         readdata_o;
	logic                waitrequest_o, dataavailable_o, readyfordata_o;
	logic                endofpacket_o, irq_o, rxd_i, cts_n_i, txd_o, rts_n_o;
	logic [15:0]         rd;
	logic                pkt_end;
	int                  bad_count = 0;
	int                  checks = 0;
	int                  cycles = 0;
	logic [7:0]          txq [3] = '{8'ha5, 8'h07, 8'h3c};
	uc_row_t             rows [4] = '{'{3'h4, 16'h0003, 16'h0003},
		'{3'h5, 16'h01a5, 16'h00a5}, '{3'h3, 16'h1800, 16'h1800},
		'{3'h6, 16'hffff, 16'h0000}};

	uc_uart #(.PARITY(uc_pkg::UC_PAR_EVEN), .STOP_BITS(2)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .dataavailable_o(dataavailable_o),
		.readyfordata_o(readyfordata_o), .endofpacket_o(endofpacket_o),
		.irq_o(irq_o), .rxd_i(rxd_i), .cts_n_i(cts_n_i), .txd_o(txd_o),
		.rts_n_o(rts_n_o)
	);
	uc_term_model #(.BIT_CLKS(4)) term (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	// Request held until the ack cycle has passed its edge
	task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d);
		int n = 0;
		@(negedge clk_i);
		bus_i <= '{cs: 1'b1, rd: !w, wr: w, addr: a, wdata: d};
		do begin
			@(negedge clk_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 400);
		if (waitrequest_o !== 1'b0) begin
			bad_count++;
		end
		rd = readdata_o;
		pkt_end = endofpacket_o;
		@(negedge clk_i);
		bus_i <= '0;
	endtask : acc

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		bus_i = '0;
		rst_i = 1'b1;
		cts_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		rst_i = 1'b0;
		cmp({waitrequest_o, txd_o, rts_n_o, irq_o}, 16'he);
		acc(1'b0, 3'h4, 16'h0);
		cmp(rd, 16'h06c8);
		acc(1'b0, 3'h5, 16'h0);
		cmp(rd, 16'h0);
		foreach (rows[i]) begin
			acc(1'b1, rows[i].a, rows[i].w);
			acc(1'b0, rows[i].a, 16'h0);
			cmp(rd, rows[i].r);
		end
		cmp(rts_n_o, 16'h0);
		// Back-to-back writes, third one must stall; line cts held inactive
		foreach (txq[i]) begin
			acc(1'b1, 3'h1, {8'h0, txq[i]});
			cmp(pkt_end, i == 0);
		end
		for (int n = 0; n < 300 && term.frames.size() < 3; n++) @(negedge clk_i);
		foreach (txq[i]) cmp(term.frames[i], {2'b11, ^txq[i], txq[i], 1'b0});
		cmp({dataavailable_o, readyfordata_o}, 16'h1);
		cmp(irq_o, 16'h1);
		acc(1'b1, 3'h2, 16'h0);
		cmp(irq_o, 16'h0);
		fork
			term.send(8'h5a, 1'b0);
			acc(1'b0, 3'h0, 16'h0);
		join
		cmp(rd, 16'h005a);
		acc(1'b0, 3'h2, 16'h0);
		cmp(rd & 16'h1001, 16'h0);
		fork
			term.send(8'ha5, 1'b1);
			acc(1'b0, 3'h0, 16'h0);
		join
		cmp(rd, 16'h00a5);
		cmp(pkt_end, 16'h1);
		acc(1'b0, 3'h2, 16'h0);
		cmp(rd & 16'h1001, 16'h1001);
		acc(1'b1, 3'h3, 16'h0c00);
		acc(1'b1, 3'h2, 16'h0);
		cts_n_i = 1'b0;
		repeat (8) @(negedge clk_i);
		cmp(irq_o, 16'h1);
		acc(1'b0, 3'h2, 16'h0);
		cmp(rd & 16'h0c00, 16'h0c00);
		// Unread character must show as available
		term.send(8'h3c, 1'b0);
		repeat (8) @(negedge clk_i);
		cmp({dataavailable_o, readyfordata_o}, 16'h3);
		give_verdict();
	end
endmodule : uart_config_options_test
`default_nettype wire
